// >>> bench/trd_far_side.sv
// Processor channel and tape station model facing the read path
`timescale 1ns/1ps
module trd_far_side (
  input wire logic clk_i,
  input wire logic strobe_i,
  input wire logic end_data_i,
  input wire logic ack_en_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic end_service_o,
  output logic [8:0] data_o,
  output logic [8:0] line_o
);
  logic [8:0] next_v = 9'h0a0;
  logic go;
  initial begin
    ack_o = 1'b0;
    end_service_o = 1'b0;
    data_o = 9'h000;
    line_o = 9'h000;
  end
  // Slow mode leaves one idle cycle after each acknowledge
  always @(negedge clk_i) begin
    go = ack_en_i && strobe_i && !(slow_i && ack_o);
    ack_o <= go;
    end_service_o <= go && end_data_i;
    data_o <= go ? next_v : ~data_o;
    if (go) next_v <= next_v + 9'h025;
  end
  task automatic send_char(input logic [8:0] c, input int hi);
    @(negedge clk_i);
    line_o = c;
    repeat (hi) @(negedge clk_i);
    line_o = 9'h000;
    repeat (150) @(negedge clk_i);
  endtask : send_char
endmodule : trd_far_side

// >>> bench/trd_read_path_asserts.sv
// Port checker for the tape read path, bound into the top module
`timescale 1ns/1ps
module trd_read_path_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic transfer_state_i,
  input wire logic read_mode_i,
  input wire logic tape_take_i,
  input wire logic tape_char_valid_o,
  input wire logic service_request_strobe_o,
  input wire logic service_ack_i,
  input wire logic [8:0] io_processor_data_o,
  input wire logic end_data_o,
  input wire logic end_service_i,
  input wire logic parity_err_o,
  input wire logic [8:0] error_pattern_o,
  input wire logic overrun_o
);
  logic [3:0] occ_q, occ_d;
  logic disc_q, disc_d;
  logic wr_on, moved;
  assign wr_on = transfer_state_i && !read_mode_i;
  assign moved = service_request_strobe_o && service_ack_i;
  // Write-side occupancy mirror; the read side fills out of sight
  always_comb begin
    occ_d = occ_q;
    disc_d = disc_q;
    if (wr_on && moved) occ_d = occ_d + 4'h1;
    if (wr_on && tape_take_i && tape_char_valid_o) occ_d = occ_d - 4'h1;
    if (moved && end_service_i) disc_d = 1'b1;
    if (!transfer_state_i || sys_rst_i) disc_d = 1'b0;
    if (sys_rst_i) occ_d = 4'h0;
  end
  always_ff @(posedge clk_i) begin
    occ_q <= occ_d;
    disc_q <= disc_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_strobe_xfer: assert property (
    service_request_strobe_o |-> transfer_state_i)
    else $error("strobe outside transfer");
  a_rst_clear: assert property (disable iff (1'b0)
    sys_rst_i |=> !parity_err_o && !overrun_o && !end_data_o
      && error_pattern_o == 9'h000)
    else $error("outputs not cleared by reset");
  a_wr_call_level: assert property (
    wr_on && !disc_q |-> service_request_strobe_o == (occ_q <= 4'h4))
    else $error("write call does not follow occupancy");
  a_wr_valid_count: assert property (
    wr_on |-> tape_char_valid_o == (occ_q != 4'h0))
    else $error("tape valid does not follow occupancy");
  a_valid_write_only: assert property (
    tape_char_valid_o |-> !read_mode_i)
    else $error("tape valid while reading");
  a_end_data_strobe: assert property (
    end_data_o |-> service_request_strobe_o)
    else $error("end data without strobe");
  a_es_disconnect: assert property (
    moved && end_service_i |=> !service_request_strobe_o [*8])
    else $error("strobe after end service");
  a_head_stable: assert property (
    read_mode_i && service_request_strobe_o && !service_ack_i
      |=> $stable(io_processor_data_o))
    else $error("read head moved without acknowledge");
  c_wr_push: cover property (wr_on && moved);
  c_rd_last: cover property (end_data_o && service_ack_i);
  c_par_bad: cover property ($rose(parity_err_o));
endmodule : trd_read_path_asserts

bind trd_read_path trd_read_path_asserts u_chk (.*);

// >>> bench/trd_read_path_tb.sv
// Self-checking bench for the tape read path
`timescale 1ns/1ps
module trd_read_path_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic xfer = 1'b0;
  logic rd = 1'b0;
  logic take = 1'b0;
  logic rec_end = 1'b0;
  logic ack_en = 1'b0;
  logic slow = 1'b0;
  logic ack, es, strobe, ed, par, ccerr, ovr, tval;
  logic [8:0] din, dout, line, tchar, epr;
  logic [8:0] exp_q[$];
  int n_mismatch = 0;
  int compares = 0;
  always #4 clk_i = ~clk_i;
  trd_read_path uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .transfer_state_i(xfer),
    .read_mode_i(rd), .correct_mode_i(1'b0), .raw_mode_i(1'b0),
    .tape_line_i(line), .skew_cfg_i({9{5'h04}}),
    .record_end_i(rec_end), .tape_take_i(take), .tape_char_o(tchar),
    .tape_char_valid_o(tval), .service_request_strobe_o(strobe),
    .service_ack_i(ack), .io_processor_data_i(din),
    .io_processor_data_o(dout), .end_data_o(ed), .end_service_i(es),
    .parity_err_o(par), .error_pattern_o(epr),
    .check_char_err_o(ccerr), .overrun_o(ovr));
  trd_far_side u_far (
    .clk_i(clk_i), .strobe_i(strobe), .end_data_i(ed),
    .ack_en_i(ack_en), .slow_i(slow), .ack_o(ack),
    .end_service_o(es), .data_o(din), .line_o(line));
  task automatic chk(input string what, input logic [8:0] e,
                     input logic [8:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && strobe !== 1'b0; i++) @(negedge clk_i);
    if (strobe !== 1'b0) begin
      n_mismatch++;
      $display("[ERR] strobe exp 0 got %b", strobe);
      test_done();
    end
  endtask : wait_idle
  // Writes log what the processor hands over; reads judge each byte
  always @(posedge clk_i) begin
    if (strobe && ack && !rd) exp_q.push_back(din);
    if (strobe && ack && rd) begin
      chk("end data", 9'(exp_q.size() == 1), 9'(ed));
      chk("read byte", exp_q.pop_front(), dout);
    end
  end
  task automatic t_reset();
    chk("strobe", 9'h000, 9'(strobe));
    chk("pattern", 9'h000, epr);
    chk("flags", 9'h000, {6'h00, par, ovr, ccerr});
    $display("Test reset done");
  endtask : t_reset
  task automatic t_write();
    int i;
    xfer = 1'b1;
    ack_en = 1'b1;
    @(negedge clk_i);
    wait_idle();
    chk("stored", 9'h005, 9'(exp_q.size()));
    ack_en = 1'b0;
    for (i = 0; i < 5; i++) begin
      @(negedge clk_i);
      chk("tape valid", 9'h001, 9'(tval));
      chk("tape char", exp_q[0], tchar);
      take = 1'b1;
      @(negedge clk_i);
      take = 1'b0;
      void'(exp_q.pop_front());
      chk("call", 9'h001, 9'(strobe));
    end
    @(negedge clk_i);
    chk("tape valid", 9'h000, 9'(tval));
    xfer = 1'b0;
    $display("Test write done");
  endtask : t_write
  task automatic t_read();
    int i;
    logic [8:0] ch [5] = '{9'h001, 9'h103, 9'h0e0, 9'h1ff, 9'h003};
    rd = 1'b1;
    u_far.send_char(9'h0f1, 20);
    xfer = 1'b1;
    u_far.send_char(9'h1ff, 3);
    for (i = 0; i < 5; i++) begin
      exp_q.push_back(ch[i]);
      u_far.send_char(ch[i], 20);
      chk("parity", 9'(~^ch[i]), 9'(par));
    end
    chk("pattern", 9'h003, epr);
    chk("call", 9'h001, 9'(strobe));
    rec_end = 1'b1;
    @(negedge clk_i);
    rec_end = 1'b0;
    chk("check char", 9'h001, 9'(ccerr));
    chk("overrun", 9'h000, 9'(ovr));
    slow = 1'b1;
    ack_en = 1'b1;
    @(negedge clk_i);
    wait_idle();
    chk("left", 9'h000, 9'(exp_q.size()));
    repeat (20) @(negedge clk_i);
    chk("no strobe", 9'h000, 9'(strobe));
    xfer = 1'b0;
    $display("Test read done");
  endtask : t_read
  initial begin
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_write();
    t_read();
    test_done();
  end
endmodule : trd_read_path_tb

// >>> core/trd_pkg.sv
// Constants shared by the tape read deskew and buffer path
package trd_pkg;
  localparam int CHANS = 9;
  localparam int PW_W = 6;
  localparam int BC_W = 5;
  localparam int DK_W = 5;
  // Pulses shorter than this many nanoseconds are noise spikes
  localparam int SPIKE_NS = 64;
  localparam int CLK_NS = 8;
  localparam logic [PW_W-1:0] SPIKE_MIN =
    PW_W'((SPIKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [BC_W-1:0] BC_END_ONE = 5'h1d;
  localparam logic [BC_W-1:0] BC_END_ZERO = 5'h1f;
  // Window in which one character's bits are gathered
  localparam int ASM_NS = 400;
  localparam logic [7:0] ASM_CYC = 8'((ASM_NS + CLK_NS - 1) / CLK_NS);
  localparam int BUF_DEPTH = 8;
  localparam int BUF_AW = 3;
  localparam logic [BUF_AW:0] CALL_WR_MAX = 4'h4;
  localparam logic [BUF_AW:0] CALL_RD_MIN = 4'h5;
  localparam logic [BUF_AW:0] OCC_ONE = 4'h1;
  typedef enum logic [1:0] {
    TRD_ASM_IDLE = 2'b00,
    TRD_ASM_GATHER = 2'b01,
    TRD_ASM_LOAD = 2'b10,
    TRD_ASM_CLEAR = 2'b11
  } trd_asm_e;
endpackage : trd_pkg

// >>> core/trd_read_path.sv
// Tape read deskew, character assembly, checking and eight-byte buffer
//
// Contract
// - Nine parallel read lines carry eight data bits plus parity.
// - Read handling only while sequencer sits in transfer state.
// - Per-channel width counter starts on rise, drops spikes, counts bits.
// - On fall, width count stops and passes to crowding counter.
// - Crowding counter loads half the received width count.
// - Crowding hand-off at 29 if previous bit one, 31 if zero.
// - Hand-off starts channel deskew counter feeding its comparator.
// - Comparator fires at configured skew, setting the assembly bit.
// - First of nine ORed comparator hits starts the assembly period.
// - Period end loads read register, then a separate clear pulse.
// - Assembly register stays clear until next comparator hit.
// - Parity checker flags every wrong read register character.
// - Normal read records parity errors in error pattern register.
// - Correction read repairs failing channel; parity goes on bus.
// - Read-after-write check character verified in error pattern reg.
// - Internal bus has nine read and nine write paths.
// - Buffer timing starts with first character of a record.
// - Each address counter steps per timing pulse, stepping occupancy.
// - Occupancy counts up per store, down per removal.
// - Service call at four or less writing, five or more reading.
// - Eight-character buffer, read by address without a clock.
// - Write register reused in reads for check character and track.
// - Each strobe answered by acknowledge moving one byte.
// - End-data asserted in the subcycle moving the last byte.
// - Disconnect after subcycle where end-service is seen.
`timescale 1ns/1ps

module trd_char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [AW:0] count_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  // No clock needed to read: the read pointer selects the entry
  assign out_data_o = mem_q[rd_ptr_q];
  assign count_o = cnt_q;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    mem_d = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_ptr_q] = in_data_i;
      wr_ptr_d = wr_ptr_q + AW'(1);
    end
    if (pop) begin
      rd_ptr_d = rd_ptr_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      mem_q <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : trd_char_fifo

module trd_read_path (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic transfer_state_i,
  input wire logic read_mode_i,
  input wire logic correct_mode_i,
  input wire logic raw_mode_i,
  input wire logic [8:0] tape_line_i,
  input wire logic [44:0] skew_cfg_i,
  input wire logic record_end_i,
  input wire logic tape_take_i,
  output logic [8:0] tape_char_o,
  output logic tape_char_valid_o,
  output logic service_request_strobe_o,
  input wire logic service_ack_i,
  input wire logic [8:0] io_processor_data_i,
  output logic [8:0] io_processor_data_o,
  output logic end_data_o,
  input wire logic end_service_i,
  output logic parity_err_o,
  output logic [8:0] error_pattern_o,
  output logic check_char_err_o,
  output logic overrun_o
);
  localparam int N = trd_pkg::CHANS;

  logic [N-1:0] meta_q, sync_q, prev_q;
  logic [N-1:0] hit;
  logic [N-1:0] rr_q, rr_d;
  logic [N-1:0] asm_q, asm_d;
  trd_pkg::trd_asm_e asm_st_q, asm_st_d;
  logic [7:0] per_q, per_d;
  logic rr_new_q, rr_new_d;
  logic active;

  // Pins cross into the master clock through two flops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= tape_line_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign active = transfer_state_i & read_mode_i;

  for (genvar c = 0; c < N; c++) begin : g_chan
    logic [trd_pkg::PW_W-1:0] pw_q, pw_d;
    logic [trd_pkg::BC_W-1:0] bc_q, bc_d;
    logic [trd_pkg::DK_W-1:0] dk_q, dk_d;
    logic pw_run_q, pw_run_d, bc_run_q, bc_run_d, dk_run_q, dk_run_d;
    logic hit_d, hit_q;
    logic [trd_pkg::DK_W-1:0] skew;
    logic [trd_pkg::BC_W-1:0] bc_end;

    assign skew = skew_cfg_i[c*trd_pkg::DK_W +: trd_pkg::DK_W];
    // Bit-crowding target depends on the last bit of this channel
    assign bc_end = rr_q[c] ? trd_pkg::BC_END_ONE
                            : trd_pkg::BC_END_ZERO;
    assign hit[c] = hit_q;

    always_comb begin
      pw_d = pw_q;
      pw_run_d = pw_run_q;
      bc_d = bc_q;
      bc_run_d = bc_run_q;
      dk_d = dk_q;
      dk_run_d = dk_run_q;
      hit_d = 1'b0;
      if (sync_q[c] && !prev_q[c]) begin
        pw_d = '0;
        pw_run_d = 1'b1;
      end else if (pw_run_q && sync_q[c]) begin
        // Saturate so a stuck line cannot wrap to a short count
        if (pw_q != '1) begin
          pw_d = pw_q + trd_pkg::PW_W'(1);
        end
      end else if (pw_run_q && !sync_q[c]) begin
        pw_run_d = 1'b0;
        if (pw_q < trd_pkg::SPIKE_MIN) begin
          pw_d = '0;
        end else begin
          bc_d = trd_pkg::BC_W'(pw_q >> 1);
          bc_run_d = 1'b1;
        end
      end
      if (bc_run_q) begin
        if (bc_q >= bc_end) begin
          bc_run_d = 1'b0;
          dk_d = '0;
          dk_run_d = 1'b1;
        end else begin
          bc_d = bc_q + trd_pkg::BC_W'(1);
        end
      end
      if (dk_run_q) begin
        if (dk_q == skew) begin
          hit_d = 1'b1;
          dk_run_d = 1'b0;
        end else begin
          dk_d = dk_q + trd_pkg::DK_W'(1);
        end
      end
      if (!active) begin
        pw_run_d = 1'b0;
        bc_run_d = 1'b0;
        dk_run_d = 1'b0;
        hit_d = 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        pw_q <= '0;
        bc_q <= '0;
        dk_q <= '0;
        pw_run_q <= 1'b0;
        bc_run_q <= 1'b0;
        dk_run_q <= 1'b0;
        hit_q <= 1'b0;
      end else begin
        pw_q <= pw_d;
        bc_q <= bc_d;
        dk_q <= dk_d;
        pw_run_q <= pw_run_d;
        bc_run_q <= bc_run_d;
        dk_run_q <= dk_run_d;
        hit_q <= hit_d;
      end
    end
  end

  // Assembly window and the two-step load then clear
  always_comb begin
    asm_st_d = asm_st_q;
    per_d = per_q;
    rr_d = rr_q;
    rr_new_d = 1'b0;
    asm_d = asm_q | hit;
    unique case (asm_st_q)
      trd_pkg::TRD_ASM_IDLE: begin
        if (|hit) begin
          asm_st_d = trd_pkg::TRD_ASM_GATHER;
          per_d = 8'h01;
        end
      end
      trd_pkg::TRD_ASM_GATHER: begin
        per_d = per_q + 8'h01;
        if (per_q >= trd_pkg::ASM_CYC) begin
          asm_st_d = trd_pkg::TRD_ASM_LOAD;
        end
      end
      trd_pkg::TRD_ASM_LOAD: begin
        rr_d = asm_q;
        rr_new_d = 1'b1;
        asm_st_d = trd_pkg::TRD_ASM_CLEAR;
      end
      trd_pkg::TRD_ASM_CLEAR: begin
        // A new hit in the clear cycle is kept: set wins
        asm_d = hit;
        asm_st_d = (|hit) ? trd_pkg::TRD_ASM_GATHER
                          : trd_pkg::TRD_ASM_IDLE;
        per_d = 8'h01;
      end
    endcase
    if (!active) begin
      asm_st_d = trd_pkg::TRD_ASM_IDLE;
      asm_d = '0;
      rr_new_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      asm_st_q <= trd_pkg::TRD_ASM_IDLE;
      per_q <= '0;
      asm_q <= '0;
      rr_q <= '0;
      rr_new_q <= 1'b0;
    end else begin
      asm_st_q <= asm_st_d;
      per_q <= per_d;
      asm_q <= asm_d;
      rr_q <= rr_d;
      rr_new_q <= rr_new_d;
    end
  end

  // Checking, correction and both halves of the internal bus
  logic perr;
  logic [N-1:0] bus_rd, bus_wr;
  logic [N-1:0] epr_q, epr_d, wreg_q, wreg_d;
  logic perr_q, perr_d, ck_err_q, ck_err_d, ovr_q, ovr_d;
  logic rec_q, rec_d;

  assign perr = ~(^rr_q);
  // In correction mode the stored track mask flips the bad bit
  assign bus_rd = (correct_mode_i && perr) ? (rr_q ^ epr_q)
                                           : rr_q;
  assign bus_wr = io_processor_data_i;

  always_comb begin
    epr_d = epr_q;
    wreg_d = wreg_q;
    perr_d = perr_q;
    ck_err_d = ck_err_q;
    if (rr_new_q) begin
      perr_d = perr;
      if (raw_mode_i) begin
        epr_d = epr_q ^ rr_q;
      end else if (!correct_mode_i && perr) begin
        epr_d = epr_q ^ rr_q;
      end
      wreg_d = wreg_q ^ bus_rd;
    end
    if (record_end_i && active) begin
      ck_err_d = raw_mode_i ? (epr_q != '0)
                            : (wreg_q != '0);
      wreg_d = '0;
    end
    if (!transfer_state_i) begin
      wreg_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      epr_q <= '0;
      wreg_q <= '0;
      perr_q <= 1'b0;
      ck_err_q <= 1'b0;
    end else begin
      epr_q <= epr_d;
      wreg_q <= wreg_d;
      perr_q <= perr_d;
      ck_err_q <= ck_err_d;
    end
  end

  // Buffer timing and the processor service subcycles
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [N-1:0] f_in_data, f_out_data;
  logic [trd_pkg::BUF_AW:0] occ;
  logic call, conn_q, conn_d, timing_q, timing_d, last;
  logic [N-1:0] out_q, out_d;

  assign f_in_valid = read_mode_i ? (rr_new_q & timing_d)
                                  : (conn_q & service_ack_i
                                     & transfer_state_i);
  assign f_in_data = read_mode_i ? bus_rd : bus_wr;
  assign f_out_ready = read_mode_i ? (conn_q & service_ack_i)
                                   : tape_take_i;
  assign last = read_mode_i & rec_q & (occ == trd_pkg::OCC_ONE);
  always_comb begin
    if (read_mode_i) begin
      call = (occ >= trd_pkg::CALL_RD_MIN) | (rec_q & f_out_valid);
    end else begin
      call = (occ <= trd_pkg::CALL_WR_MAX);
    end
  end

  assign service_request_strobe_o = conn_q & transfer_state_i & call;
  assign end_data_o = service_request_strobe_o & last;
  assign io_processor_data_o = f_out_data;
  assign tape_char_o = out_q;
  assign tape_char_valid_o = f_out_valid & ~read_mode_i;
  assign parity_err_o = perr_q;
  assign error_pattern_o = epr_q;
  assign check_char_err_o = ck_err_q;
  assign overrun_o = ovr_q;

  always_comb begin
    conn_d = conn_q;
    timing_d = timing_q;
    rec_d = rec_q;
    ovr_d = ovr_q;
    out_d = f_out_valid ? f_out_data : out_q;
    if (rr_new_q && active) begin
      timing_d = 1'b1;
    end
    if (record_end_i && active) begin
      rec_d = 1'b1;
    end
    if (f_in_valid && !f_in_ready) begin
      ovr_d = 1'b1;
    end
    if (service_request_strobe_o && service_ack_i && end_service_i) begin
      conn_d = 1'b0;
    end
    if (!transfer_state_i) begin
      conn_d = 1'b1;
      timing_d = 1'b0;
      rec_d = 1'b0;
      ovr_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      conn_q <= 1'b1;
      timing_q <= 1'b0;
      rec_q <= 1'b0;
      ovr_q <= 1'b0;
      out_q <= '0;
    end else begin
      conn_q <= conn_d;
      timing_q <= timing_d;
      rec_q <= rec_d;
      ovr_q <= ovr_d;
      out_q <= out_d;
    end
  end

  trd_char_fifo #(
    .WIDTH(N),
    .DEPTH(trd_pkg::BUF_DEPTH),
    .AW(trd_pkg::BUF_AW)
  ) u_buf (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in_data),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out_data),
    .count_o(occ)
  );
endmodule : trd_read_path
